/* hw/sdpt_cfg.v */
// Power-down, extra timing, memory-type and strobe delay-lock logic with APB registers
`timescale 1ns/100ps
`include "sdpt_cfg_regs.vh"

// What this block does
// - Writes to timing, low-power, memory-select, high-speed registers ignored while protected.
// - DDR2 fast power-down exit waits programmed 0-15 cycles before a read.
// - DDR2 slow power-down exit waits separate 0-15 cycle count before read.
// - DDR2 precharge-all blocks any next command for programmed 0-15 cycles.
// - Precharge after read spaced by programmed 0-15 cycles, reset 0.
// - Low-power command 00 never issues power-down, self refresh or deep power-down.
// - Command 01 enters self refresh, stops clock, drops CKE, leaves per access.
// - Command 10 powers down with CKE low after each access, exits for access.
// - Command 11 issues deep power-down, only for low-power SDRAM types.
// - Clock-freeze bit holds memory clock low in power-down or deep power-down.
// - Partial-array field selects quarter, half or all banks kept refreshed.
// - Temperature field sets self-refresh interval, reset zero.
// - After init, change of extended fields triggers automatic extended mode update.
// - Timeout 00 enters low power at once, 01 after 64, 10 after 128.
// - DDR2 power-down exit bit: 0 fast, 1 slow, reset slow.
// - Update policy: 00 off, 01 at refresh with pending access, 10 before self refresh.
// - Memory type field: 000 SDR, 001 LPSDR, 011 LPDDR1, 110 DDR2.
// - Bus width bit: 0 is 32-bit, not for SDR; 1 is 16-bit.
// - Incoming DQS is delayed by the master delay to centre in data window.
// - Status shows delay counter incrementing, decrementing and its present value.
// - Counter at maximum stops, forces lock, sets overflow flag.
// - Read-anticipation disable bit: 1 disables, reset 1, 0 enables.
module sdpt_cfg #(
  parameter DELAY_W = 8
) (
  // Clock and reset
  input  wire               clk,
  input  wire               rst_n,
  // APB slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [7:0]         paddr,
  input  wire [31:0]        pwdata,
  output wire               pready,
  output wire               pslverr,
  output reg  [31:0]        prdata,
  // Controller core side
  input  wire               initDone,
  input  wire               accessReq,
  input  wire               xferStart,
  input  wire               xferBusy,
  input  wire               readIssued,
  input  wire               prechargeAllIssued,
  input  wire               refreshIssued,
  output wire               accessGrant,
  output wire               readBlocked,
  output wire               prechargeBlocked,
  output wire               commandBlocked,
  output reg                emrUpdateReq,
  output wire [2:0]         memoryType,
  output wire               busWidthSelect,
  output wire               readAnticipationDisable,
  output wire [2:0]         partialArrayRefresh,
  output wire [1:0]         tempCompRefresh,
  output wire [1:0]         outputDriveStrength,
  output wire               powerdownExitSpeed,
  // Memory low-power pins
  output reg                ckeOut,
  output reg                memClkRun,
  output reg                selfRefreshCmd,
  output reg                powerDownCmd,
  output reg                deepPowerDownCmd,
  // Strobe delay-lock
  input  wire               dqsPin,
  input  wire               phaseLagPin,
  input  wire               phaseLeadPin,
  output wire [DELAY_W-1:0] masterDelayValue,
  output reg                dqsCentred
);

  localparam [DELAY_W-1:0] DELAY_MAX = {DELAY_W{1'b1}};
  localparam [2:0] ST_ACTIVE = 3'h0;
  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_ENTER  = 3'h2;
  localparam [2:0] ST_LOW    = 3'h3;
  localparam [2:0] ST_EXIT   = 3'h4;

  // Registers
  reg [15:0]        timing3_q;
  reg [31:0]        lowPower_q;
  reg [4:0]         memSelect_q;
  reg               hiSpeed_q;
  reg               writeProtect_q;
  reg [2:0]         state_q;
  reg [7:0]         idleCnt_q;
  reg [3:0]         readHold_q;
  reg [3:0]         preHold_q;
  reg [3:0]         cmdHold_q;
  reg               emrPending_q;
  reg [DELAY_W-1:0] masterDelay_q;
  reg               masterInc_q;
  reg               masterDec_q;
  reg               masterOvf_q;
  reg [DELAY_W-1:0] dqsCnt_q;
  reg               dqsArmed_q;
  reg [1:0]         dqsSync_q;
  reg [1:0]         lagSync_q;
  reg [1:0]         leadSync_q;
  reg               dqsPrev_q;

  // Field views
  wire [3:0] fastExitDelay = timing3_q[`SDPT_FAST_EXIT_LSB +: 4];
  wire [3:0] slowExitDelay = timing3_q[`SDPT_SLOW_EXIT_LSB +: 4];
  wire [3:0] preAllDelay   = timing3_q[`SDPT_PRE_ALL_LSB +: 4];
  wire [3:0] rdPreDelay    = timing3_q[`SDPT_RD_PRE_LSB +: 4];
  wire [1:0] lowPowerCmd   = lowPower_q[`SDPT_LPCMD_LSB +: 2];
  wire       clockFreeze   = lowPower_q[`SDPT_CLKFRZ_BIT];
  wire [1:0] lpTimeout     = lowPower_q[`SDPT_TIMEOUT_LSB +: 2];
  wire [1:0] updatePolicy  = lowPower_q[`SDPT_UPDMR_LSB +: 2];
  wire       isDdr2        = memoryType == `SDPT_MT_DDR2;
  wire       isLowPowerMem = memoryType == `SDPT_MT_LPSDR || memoryType == `SDPT_MT_LPDDR1;

  assign memoryType              = memSelect_q[`SDPT_MEMTYPE_LSB +: 3];
  assign busWidthSelect          = memSelect_q[`SDPT_BUSW_BIT];
  assign readAnticipationDisable = hiSpeed_q;
  assign partialArrayRefresh     = lowPower_q[`SDPT_PARTIAL_ARRAY_REFRESH_LSB +: 3];
  assign tempCompRefresh         = lowPower_q[`SDPT_TCR_LSB +: 2];
  assign outputDriveStrength     = lowPower_q[`SDPT_DS_LSB +: 2];
  assign powerdownExitSpeed      = lowPower_q[`SDPT_POWERDOWN_EXIT_SPEED_BIT];
  assign masterDelayValue        = masterDelay_q;

  // Decode used by both the error response and the write path
  function mapped;
    input [7:0] a;
    begin
      mapped = a == `SDPT_OFF_TIMING3 || a == `SDPT_OFF_LOWPOWER ||
               a == `SDPT_OFF_MEMSELECT || a == `SDPT_OFF_DLLSTATUS ||
               a == `SDPT_OFF_HISPEED || a == `SDPT_OFF_WRPROTECT ||
               a == `SDPT_OFF_LPSTATUS;
    end
  endfunction

  // Zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);

  wire wrStrobe   = psel & penable & pwrite & mapped(paddr);
  wire wrAllowed  = wrStrobe & ~writeProtect_q;
  wire wrTiming3  = wrAllowed && paddr == `SDPT_OFF_TIMING3;
  wire wrLowPower = wrAllowed && paddr == `SDPT_OFF_LOWPOWER;
  wire wrMemSel   = wrAllowed && paddr == `SDPT_OFF_MEMSELECT;
  wire wrHiSpeed  = wrAllowed && paddr == `SDPT_OFF_HISPEED;
  wire wrProtect  = wrStrobe && paddr == `SDPT_OFF_WRPROTECT &&
                    pwdata[`SDPT_WP_KEY_LSB +: 24] == `SDPT_WP_KEY;

  // Extended mode fields that force a mode register rewrite
  wire [31:0] lpNew     = pwdata & 32'h0031_7FF7;
  wire        emrChange = wrLowPower && initDone &&
                          (lpNew[`SDPT_PARTIAL_ARRAY_REFRESH_LSB +: 3] != partialArrayRefresh ||
                           lpNew[`SDPT_TCR_LSB +: 2] != tempCompRefresh ||
                           lpNew[`SDPT_DS_LSB +: 2] != outputDriveStrength ||
                           lpNew[`SDPT_POWERDOWN_EXIT_SPEED_BIT] != powerdownExitSpeed);

  // Memory type reserved code is refused; SDR always runs the 16-bit bus
  wire [2:0] mtNew   = pwdata[`SDPT_MEMTYPE_LSB +: 3];
  wire       mtValid = mtNew == `SDPT_MT_SDR || mtNew == `SDPT_MT_LPSDR ||
                       mtNew == `SDPT_MT_LPDDR1 || mtNew == `SDPT_MT_DDR2;

  always @(posedge clk) begin
    if (!rst_n) begin
      timing3_q      <= `SDPT_TIMING3_RESET;
      lowPower_q     <= `SDPT_LOWPOWER_RESET;
      memSelect_q    <= `SDPT_MEMSELECT_RESET;
      hiSpeed_q      <= `SDPT_HISPEED_RESET;
      writeProtect_q <= 1'b0;
    end else begin
      if (wrTiming3)
        timing3_q <= pwdata[15:0];
      if (wrLowPower)
        lowPower_q <= lpNew;
      if (wrMemSel && mtValid) begin
        memSelect_q[2:0] <= mtNew;
        memSelect_q[3]   <= 1'b0;
        memSelect_q[4]   <= pwdata[`SDPT_BUSW_BIT] | (mtNew == `SDPT_MT_SDR);
      end
      if (wrHiSpeed)
        hiSpeed_q <= pwdata[`SDPT_ANTICIP_BIT];
      if (wrProtect)
        writeProtect_q <= pwdata[0];
    end
  end

  // Read mux, registered in the setup cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SDPT_OFF_TIMING3:   prdata <= {16'h0000, timing3_q};
        `SDPT_OFF_LOWPOWER:  prdata <= lowPower_q;
        `SDPT_OFF_MEMSELECT: prdata <= {27'h0000000, memSelect_q};
        `SDPT_OFF_DLLSTATUS: prdata <= {{(24 - DELAY_W){1'b0}}, masterDelay_q, 5'h00,
                                        masterOvf_q, masterDec_q, masterInc_q};
        `SDPT_OFF_HISPEED:   prdata <= {29'h00000000, hiSpeed_q, 2'h0};
        `SDPT_OFF_WRPROTECT: prdata <= {31'h00000000, writeProtect_q};
        `SDPT_OFF_LPSTATUS:  prdata <= {24'h000000, emrPending_q, state_q, 3'h0, ckeOut};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Idle timeout limit
  reg [7:0] idleLimit;
  always @* begin
    case (lpTimeout)
      `SDPT_TO_64:  idleLimit = `SDPT_IDLE_64;
      `SDPT_TO_128: idleLimit = `SDPT_IDLE_128;
      default:      idleLimit = 8'd0;
    endcase
  end

  // Deep power-down only makes sense for low-power parts; reserved timeout never enters
  wire lpEnabled = lowPowerCmd != `SDPT_LP_NONE && lpTimeout != 2'h3 &&
                   (lowPowerCmd != `SDPT_LP_DEEPPD || isLowPowerMem);
  wire idleDone  = idleCnt_q >= idleLimit;
  wire emrBeforeSr = updatePolicy == `SDPT_UPD_UNSHARED && emrPending_q &&
                     lowPowerCmd == `SDPT_LP_SELFREF;

  // Low-power sequencer
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q          <= ST_ACTIVE;
      idleCnt_q        <= 8'd0;
      ckeOut           <= 1'b1;
      memClkRun        <= 1'b1;
      selfRefreshCmd   <= 1'b0;
      powerDownCmd     <= 1'b0;
      deepPowerDownCmd <= 1'b0;
    end else begin
      selfRefreshCmd   <= 1'b0;
      powerDownCmd     <= 1'b0;
      deepPowerDownCmd <= 1'b0;
      case (state_q)
        ST_ACTIVE: begin
          idleCnt_q <= 8'd0;
          if (!xferBusy && !accessReq && lpEnabled && initDone)
            state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          if (xferStart || xferBusy || accessReq || !lpEnabled) begin
            idleCnt_q <= 8'd0;
            state_q   <= ST_ACTIVE;
          end else if (idleDone) begin
            state_q <= ST_ENTER;
          end else begin
            idleCnt_q <= idleCnt_q + 8'd1;
          end
        end
        ST_ENTER: begin
          if (accessReq || !lpEnabled) begin
            state_q <= ST_ACTIVE;
          end else if (!emrBeforeSr && !emrUpdateReq) begin
            ckeOut  <= 1'b0;
            state_q <= ST_LOW;
            case (lowPowerCmd)
              `SDPT_LP_SELFREF: begin
                selfRefreshCmd <= 1'b1;
                memClkRun      <= 1'b0;
              end
              `SDPT_LP_PWRDOWN: begin
                powerDownCmd <= 1'b1;
                memClkRun    <= ~clockFreeze;
              end
              default: begin
                deepPowerDownCmd <= 1'b1;
                memClkRun        <= ~clockFreeze;
              end
            endcase
          end
        end
        ST_LOW: begin
          if (accessReq || !lpEnabled) begin
            ckeOut    <= 1'b1;
            memClkRun <= 1'b1;
            state_q   <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          if (readHold_q == 4'd0)
            state_q <= ST_ACTIVE;
        end
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end

  // Only a DDR2 power-down exit carries the programmed read delay
  wire exitToRead = state_q == ST_LOW && (accessReq || !lpEnabled) && isDdr2 &&
                    lowPowerCmd == `SDPT_LP_PWRDOWN;

  assign accessGrant      = state_q == ST_ACTIVE || state_q == ST_IDLE ||
                            (state_q == ST_EXIT && readHold_q == 4'd0);
  assign readBlocked      = readHold_q != 4'd0 || cmdHold_q != 4'd0;
  assign prechargeBlocked = preHold_q != 4'd0 || cmdHold_q != 4'd0;
  assign commandBlocked   = cmdHold_q != 4'd0;

  // Command spacing counters
  always @(posedge clk) begin
    if (!rst_n) begin
      readHold_q <= 4'd0;
      preHold_q  <= 4'd0;
      cmdHold_q  <= 4'd0;
    end else begin
      if (exitToRead)
        readHold_q <= powerdownExitSpeed ? slowExitDelay : fastExitDelay;
      else if (readHold_q != 4'd0)
        readHold_q <= readHold_q - 4'd1;
      if (readIssued)
        preHold_q <= rdPreDelay;
      else if (preHold_q != 4'd0)
        preHold_q <= preHold_q - 4'd1;
      if (prechargeAllIssued && isDdr2)
        cmdHold_q <= preAllDelay;
      else if (cmdHold_q != 4'd0)
        cmdHold_q <= cmdHold_q - 4'd1;
    end
  end

  // Extended mode register update; a new change in the issue cycle keeps it pending
  wire emrFireShared = updatePolicy == `SDPT_UPD_SHARED && emrPending_q &&
                       refreshIssued && accessReq;
  wire emrFire       = emrFireShared || (state_q == ST_ENTER && emrBeforeSr);
  always @(posedge clk) begin
    if (!rst_n) begin
      emrPending_q <= 1'b0;
      emrUpdateReq <= 1'b0;
    end else begin
      emrUpdateReq <= emrFire;
      if (emrChange && updatePolicy != `SDPT_UPD_OFF)
        emrPending_q <= 1'b1;
      else if (emrFire)
        emrPending_q <= 1'b0;
    end
  end

  // Pin synchronisers
  always @(posedge clk) begin
    if (!rst_n) begin
      dqsSync_q  <= 2'b00;
      lagSync_q  <= 2'b00;
      leadSync_q <= 2'b00;
      dqsPrev_q  <= 1'b0;
    end else begin
      dqsSync_q  <= {dqsSync_q[0], dqsPin};
      lagSync_q  <= {lagSync_q[0], phaseLagPin};
      leadSync_q <= {leadSync_q[0], phaseLeadPin};
      dqsPrev_q  <= dqsSync_q[1];
    end
  end

  // Master delay tracking; saturation forces lock until reset
  always @(posedge clk) begin
    if (!rst_n) begin
      masterDelay_q <= {DELAY_W{1'b0}};
      masterInc_q   <= 1'b0;
      masterDec_q   <= 1'b0;
      masterOvf_q   <= 1'b0;
    end else begin
      masterInc_q <= 1'b0;
      masterDec_q <= 1'b0;
      if (!masterOvf_q) begin
        if (lagSync_q[1] && !leadSync_q[1]) begin
          if (masterDelay_q == DELAY_MAX) begin
            masterOvf_q <= 1'b1;
          end else begin
            masterDelay_q <= masterDelay_q + 1'b1;
            masterInc_q   <= 1'b1;
          end
        end else if (leadSync_q[1] && !lagSync_q[1] && masterDelay_q != {DELAY_W{1'b0}}) begin
          masterDelay_q <= masterDelay_q - 1'b1;
          masterDec_q   <= 1'b1;
        end
      end
    end
  end

  // Strobe centring: the latest DQS edge is re-issued after the master delay
  wire dqsEdge = dqsSync_q[1] ^ dqsPrev_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      dqsCnt_q   <= {DELAY_W{1'b0}};
      dqsArmed_q <= 1'b0;
      dqsCentred <= 1'b0;
    end else begin
      dqsCentred <= 1'b0;
      if (dqsEdge) begin
        dqsCnt_q   <= masterDelay_q;
        dqsArmed_q <= 1'b1;
      end else if (dqsArmed_q) begin
        if (dqsCnt_q == {DELAY_W{1'b0}}) begin
          dqsArmed_q <= 1'b0;
          dqsCentred <= 1'b1;
        end else begin
          dqsCnt_q <= dqsCnt_q - 1'b1;
        end
      end
    end
  end

endmodule

/* hw/sdpt_cfg_regs.vh */
// Register offsets, field positions, reset values and timing counts of the power/timing block
`ifndef SDPT_CFG_REGS_VH
`define SDPT_CFG_REGS_VH

// Register byte offsets
`define SDPT_OFF_TIMING3     8'h00
`define SDPT_OFF_LOWPOWER    8'h04
`define SDPT_OFF_MEMSELECT   8'h08
`define SDPT_OFF_DLLSTATUS   8'h0C
`define SDPT_OFF_HISPEED     8'h10
`define SDPT_OFF_WRPROTECT   8'h14
`define SDPT_OFF_LPSTATUS    8'h18

// Third timing register fields
`define SDPT_FAST_EXIT_LSB   0
`define SDPT_SLOW_EXIT_LSB   4
`define SDPT_PRE_ALL_LSB     8
`define SDPT_RD_PRE_LSB      12
`define SDPT_TIMING3_RESET   16'h0000

// Low-power register fields
`define SDPT_LPCMD_LSB       0
`define SDPT_CLKFRZ_BIT      2
`define SDPT_PARTIAL_ARRAY_REFRESH_LSB        4
`define SDPT_TCR_LSB         8
`define SDPT_DS_LSB          10
`define SDPT_TIMEOUT_LSB     12
`define SDPT_POWERDOWN_EXIT_SPEED_BIT        16
`define SDPT_UPDMR_LSB       20
`define SDPT_LOWPOWER_RESET  32'h0001_0000

// Memory select fields
`define SDPT_MEMTYPE_LSB     0
`define SDPT_BUSW_BIT        4
`define SDPT_MT_SDR          3'h0
`define SDPT_MT_LPSDR        3'h1
`define SDPT_MT_RSVD         3'h2
`define SDPT_MT_LPDDR1       3'h3
`define SDPT_MT_DDR2         3'h6
`define SDPT_MEMSELECT_RESET 5'h10

// High speed register
`define SDPT_ANTICIP_BIT     2
`define SDPT_HISPEED_RESET   1'b1

// Write protect
`define SDPT_WP_KEY          24'h444452
`define SDPT_WP_KEY_LSB      8

// Low-power commands and timeouts
`define SDPT_LP_NONE         2'h0
`define SDPT_LP_SELFREF      2'h1
`define SDPT_LP_PWRDOWN      2'h2
`define SDPT_LP_DEEPPD       2'h3
`define SDPT_TO_NOW          2'h0
`define SDPT_TO_64           2'h1
`define SDPT_TO_128          2'h2
`define SDPT_IDLE_64         8'd64
`define SDPT_IDLE_128        8'd128

// Mode register update policies
`define SDPT_UPD_OFF         2'h0
`define SDPT_UPD_SHARED      2'h1
`define SDPT_UPD_UNSHARED    2'h2

`endif

/* testbench/sdpt_cfg_assertions.sv */
// Port-level assertions of the power and timing configuration block
`timescale 1ns/100ps
module sdpt_cfg_assertions #(
  parameter DELAY_W = 8
) (
  // Clock and reset
  input wire               clk,
  input wire               rst_n,
  // Observed ports
  input wire               accessReq,
  input wire               ckeOut,
  input wire               memClkRun,
  input wire               selfRefreshCmd,
  input wire               powerDownCmd,
  input wire               deepPowerDownCmd,
  input wire [2:0]         memoryType,
  input wire               busWidthSelect,
  input wire               readAnticipationDisable,
  input wire               powerdownExitSpeed,
  input wire [DELAY_W-1:0] masterDelayValue
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_asleep; !ckeOut && !accessReq; endsequence
  sequence s_awake; ckeOut && memClkRun; endsequence

  property p_pdCke; powerDownCmd |-> !ckeOut; endproperty
  a_pdCke: assert property (p_pdCke) else $error("power-down with CKE high");
  property p_srClk; selfRefreshCmd |-> !ckeOut && !memClkRun; endproperty
  a_srClk: assert property (p_srClk) else $error("self refresh clock or CKE on");
  property p_deepType; deepPowerDownCmd |-> memoryType == 3'h1 || memoryType == 3'h3;
  endproperty
  a_deepType: assert property (p_deepType) else $error("deep power-down bad type");
  property p_onePulse;
    (selfRefreshCmd || powerDownCmd) |=> !(selfRefreshCmd || powerDownCmd);
  endproperty
  a_onePulse: assert property (p_onePulse) else $error("entry pulse too long");
  property p_stayLow; s_asleep |=> !ckeOut; endproperty
  a_stayLow: assert property (p_stayLow) else $error("CKE rose without access");
  property p_wake; !ckeOut && accessReq |=> s_awake; endproperty
  a_wake: assert property (p_wake) else $error("no wake on access");
  property p_resetVals;
    $rose(rst_n) |-> memoryType == 3'h0 && busWidthSelect && readAnticipationDisable
      && powerdownExitSpeed;
  endproperty
  a_resetVals: assert property (p_resetVals) else $error("bad field reset value");
  property p_noRsvd; memoryType != 3'h2; endproperty
  a_noRsvd: assert property (p_noRsvd) else $error("reserved memory type held");
  property p_sdrWidth; memoryType == 3'h0 |-> busWidthSelect; endproperty
  a_sdrWidth: assert property (p_sdrWidth) else $error("SDR with wide bus");
  property p_ovfHold; &masterDelayValue |=> &masterDelayValue; endproperty
  a_ovfHold: assert property (p_ovfHold) else $error("delay left its maximum");
endmodule

bind sdpt_cfg sdpt_cfg_assertions #(.DELAY_W(DELAY_W)) sdpt_cfg_assertions_i (
  .clk(clk), .rst_n(rst_n), .accessReq(accessReq), .ckeOut(ckeOut), .memClkRun(memClkRun),
  .selfRefreshCmd(selfRefreshCmd), .powerDownCmd(powerDownCmd),
  .deepPowerDownCmd(deepPowerDownCmd), .memoryType(memoryType),
  .busWidthSelect(busWidthSelect), .readAnticipationDisable(readAnticipationDisable),
  .powerdownExitSpeed(powerdownExitSpeed), .masterDelayValue(masterDelayValue)
);

/* testbench/sdpt_mem_model.sv */
// Memory-side model: returned strobe and delay-line phase feedback
`timescale 1ns/100ps
module sdpt_mem_model (
  // Controller side
  input  wire clk,
  input  wire ckeOut,
  input  wire memClkRun,
  input  wire lagMode,
  // Returned strobe and phase
  output reg  dqsPin,
  output reg  phaseLagPin,
  output reg  phaseLeadPin
);
  initial dqsPin = 1'b0;
  initial phaseLagPin = 1'b0;
  initial phaseLeadPin = 1'b0;
  // Strobe stands still while the memory clock is stopped
  always #160 dqsPin = (ckeOut && memClkRun) ? ~dqsPin : 1'b0;
  // Phase compare only means something with the clock running
  always @(posedge clk) begin
    phaseLagPin <= lagMode && memClkRun;
    phaseLeadPin <= !lagMode && memClkRun && dqsPin;
  end
endmodule

/* testbench/testbench.sv */
// Self-checking bench of the power and timing configuration block
`timescale 1ns/100ps
`include "sdpt_cfg_regs.vh"
module testbench;
  reg         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         initDone = 1'b0, accessReq = 1'b1, xferStart = 1'b0, lagMode = 1'b0;
  reg         readIssued = 1'b0, prechargeAllIssued = 1'b0, err;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, rdv, rnd = 32'hE571DCD7;
  reg  [2:0]  kind;
  reg  [2:0]  types [0:3];
  integer     failures = 0, cmp_count = 0, i, n, e0, emrCount = 0;
  integer     nt [0:2];
  wire        pready, pslverr, accessGrant, readBlocked, prechargeBlocked, commandBlocked;
  wire        emrUpdateReq, busWidthSelect, readAnticipationDisable, powerdownExitSpeed;
  wire        ckeOut, memClkRun, selfRefreshCmd, powerDownCmd, deepPowerDownCmd;
  wire        dqsPin, phaseLagPin, phaseLeadPin, dqsCentred;
  wire [31:0] prdata;
  wire [2:0]  memoryType, partialArrayRefresh;
  wire [1:0]  tempCompRefresh, outputDriveStrength;
  wire [7:0]  masterDelayValue;

  sdpt_cfg #(.DELAY_W(8)) sdpt_cfg_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .initDone(initDone), .accessReq(accessReq), .xferStart(xferStart), .xferBusy(1'b0),
    .readIssued(readIssued), .prechargeAllIssued(prechargeAllIssued), .refreshIssued(1'b0),
    .accessGrant(accessGrant), .readBlocked(readBlocked), .prechargeBlocked(prechargeBlocked),
    .commandBlocked(commandBlocked), .emrUpdateReq(emrUpdateReq), .memoryType(memoryType),
    .busWidthSelect(busWidthSelect), .readAnticipationDisable(readAnticipationDisable),
    .partialArrayRefresh(partialArrayRefresh), .tempCompRefresh(tempCompRefresh),
    .outputDriveStrength(outputDriveStrength), .powerdownExitSpeed(powerdownExitSpeed),
    .ckeOut(ckeOut), .memClkRun(memClkRun), .selfRefreshCmd(selfRefreshCmd),
    .powerDownCmd(powerDownCmd), .deepPowerDownCmd(deepPowerDownCmd), .dqsPin(dqsPin),
    .phaseLagPin(phaseLagPin), .phaseLeadPin(phaseLeadPin),
    .masterDelayValue(masterDelayValue), .dqsCentred(dqsCentred)
  );
  sdpt_mem_model sdpt_mem_model_i (
    .clk(clk), .ckeOut(ckeOut), .memClkRun(memClkRun), .lagMode(lagMode),
    .dqsPin(dqsPin), .phaseLagPin(phaseLagPin), .phaseLeadPin(phaseLeadPin)
  );

  always #20 clk = ~clk;
  always @(posedge clk) if (emrUpdateReq === 1'b1) emrCount <= emrCount + 1;

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // SDR cannot run the wide bus, so its width reads back as 16 bits
  function [31:0] expMd(input [2:0] t, input w);
    expMd = {27'h0, (t == 3'h0) | w, 1'b0, t};
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
    end
  endtask
  task spacing(input k, input [31:0] exp);
    begin
      if (k) prechargeAllIssued <= 1'b1;
      else readIssued <= 1'b1;
      @(posedge clk);
      readIssued <= 1'b0;
      prechargeAllIssued <= 1'b0;
      n = 0;
      #1;
      while ((k ? commandBlocked : prechargeBlocked) === 1'b1 && n < 40) begin
        n = n + 1;
        @(posedge clk);
        #1;
      end
      chk(n, exp);
      @(posedge clk);
    end
  endtask
  // Drops the access request and counts edges to the first entry pulse
  task lpWait(input xs);
    begin
      accessReq <= 1'b0;
      n = 0;
      kind = 3'b000;
      while (kind === 3'b000 && n < 400) begin
        @(posedge clk);
        xferStart <= xs && n == 30;
        if (xs && n == 30) begin
          xs = 1'b0;
          n = 0;
        end
        kind = {selfRefreshCmd, powerDownCmd, deepPowerDownCmd};
        n = n + 1;
      end
    end
  endtask
  task wake;
    begin
      accessReq <= 1'b1;
      repeat (2) @(posedge clk);
      chk(ckeOut, 1'b1);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #(40 * 20000);
    failures = failures + 1;
    report_and_stop;
  end

  initial begin
    types[0] = 3'h0;
    types[1] = 3'h1;
    types[2] = 3'h3;
    types[3] = 3'h6;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`SDPT_OFF_TIMING3, 32'h0);
    rd(`SDPT_OFF_LOWPOWER, 32'h00010000);
    rd(`SDPT_OFF_MEMSELECT, 32'h10);
    rd(`SDPT_OFF_HISPEED, 32'h4);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      apb(1'b1, `SDPT_OFF_TIMING3, rnd);
      rd(`SDPT_OFF_TIMING3, {16'h0, rnd[15:0]});
      rnd = lfsr(rnd);
      apb(1'b1, `SDPT_OFF_MEMSELECT, {27'h0, rnd[0], 1'b0, types[i]});
      rd(`SDPT_OFF_MEMSELECT, expMd(types[i], rnd[0]));
      chk(memoryType, types[i]);
    end
    apb(1'b1, `SDPT_OFF_MEMSELECT, 32'h12);
    rd(`SDPT_OFF_MEMSELECT, expMd(3'h6, rnd[0]));
    apb(1'b1, `SDPT_OFF_TIMING3, 32'h5300);
    spacing(1'b0, 5);
    spacing(1'b1, 3);
    apb(1'b1, `SDPT_OFF_WRPROTECT, {24'h444452, 8'h01});
    apb(1'b1, `SDPT_OFF_TIMING3, 32'hFFFF);
    rd(`SDPT_OFF_TIMING3, 32'h5300);
    apb(1'b1, `SDPT_OFF_HISPEED, 32'h0);
    rd(`SDPT_OFF_HISPEED, 32'h4);
    apb(1'b1, `SDPT_OFF_WRPROTECT, {24'h444453, 8'h00});
    apb(1'b1, `SDPT_OFF_TIMING3, 32'h1111);
    rd(`SDPT_OFF_TIMING3, 32'h5300);
    apb(1'b1, `SDPT_OFF_WRPROTECT, {24'h444452, 8'h00});
    apb(1'b1, `SDPT_OFF_HISPEED, 32'h0);
    chk(readAnticipationDisable, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `SDPT_OFF_MEMSELECT, 32'h11);
    initDone <= 1'b1;
    apb(1'b1, `SDPT_OFF_LOWPOWER, 32'h0);
    lpWait(1'b0);
    chk(kind, 3'b000);
    wake;
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b1, `SDPT_OFF_LOWPOWER, (i << 12) | 32'h2);
      lpWait(1'b0);
      nt[i] = n;
      chk(kind, 3'b010);
      chk({ckeOut, accessGrant, memClkRun}, 3'b001);
      wake;
    end
    chk(nt[1] - nt[0], 64);
    chk(nt[2] - nt[1], 64);
    apb(1'b1, `SDPT_OFF_LOWPOWER, 32'h1002);
    lpWait(1'b1);
    chk(n >= nt[1] && n <= nt[1] + 2, 1);
    wake;
    apb(1'b1, `SDPT_OFF_LOWPOWER, 32'h00200001);
    e0 = emrCount;
    apb(1'b1, `SDPT_OFF_LOWPOWER, 32'h00200D11);
    lpWait(1'b0);
    chk(kind, 3'b100);
    chk({tempCompRefresh, outputDriveStrength, partialArrayRefresh}, 7'h39);
    chk(memClkRun, 1'b0);
    chk(emrCount - e0, 1);
    wake;
    apb(1'b1, `SDPT_OFF_LOWPOWER, 32'h7);
    lpWait(1'b0);
    chk(kind, 3'b001);
    @(posedge clk);
    chk(memClkRun, 1'b0);
    wake;
    apb(1'b1, `SDPT_OFF_LOWPOWER, 32'h0);
    lagMode <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, `SDPT_OFF_DLLSTATUS, 32'h0);
    chk(rdv[0], 1'b1);
    repeat (300) @(posedge clk);
    apb(1'b0, `SDPT_OFF_DLLSTATUS, 32'h0);
    chk(rdv & 32'hFF04, 32'hFF04);
    report_and_stop;
  end
endmodule
